// File: design/tefs_defines.svh
/*
 * Offsets, field positions, reset values and timing counts of the event,
 * fault and status block. Assumes inclusion by bare name, once or more.
 */
`ifndef TEFS_DEFINES_SVH
`define TEFS_DEFINES_SVH

// Register indices; the byte address is four times the index.
`define TEFS_IDX_EVA      8'h08
`define TEFS_IDX_EVB      8'h09
`define TEFS_IDX_IEN      8'h0C
`define TEFS_IDX_FLG      8'h0D
`define TEFS_IDX_STA      8'h0E
`define TEFS_IDX_FMA      8'h10
`define TEFS_IDX_CMD      8'h18
`define TEFS_IDX_CTL      8'h19
`define TEFS_IDX_CMPBH    8'h1A

// Event control fields.
`define TEFS_EV_CFG_HI    7
`define TEFS_EV_CFG_LO    6
`define TEFS_EV_POL       4
`define TEFS_EV_ACT       2
`define TEFS_EV_TRIG      0
`define TEFS_EV_MASK      8'hD5

// Interrupt enable and flag bits.
`define TEFS_IRQ_TRB      3
`define TEFS_IRQ_TRA      2
`define TEFS_IRQ_OVF      0
`define TEFS_IRQ_MASK     8'h0D

// Status bits.
`define TEFS_ST_ACTB      7
`define TEFS_ST_ACTA      6
`define TEFS_ST_COMMAND_READY    1
`define TEFS_ST_ENABLE_READY     0

// Command strobe bits.
`define TEFS_CMD_LDEOC    0
`define TEFS_CMD_LDNOW    1
`define TEFS_CMD_RST      2
`define TEFS_CMD_CAPA     3
`define TEFS_CMD_CAPB     4
`define TEFS_CMD_DISABLE_AT_CYCLE_END_STROBE   7

// Control bits.
`define TEFS_CTL_EN       0
`define TEFS_CTL_AUTO     1
`define TEFS_CTL_RUN_DURING_BREAK   2

`define TEFS_FMA_MASK     8'h0F
`define TEFS_RST_VAL      8'h00

// Filter run length and the crossing latency into the timer domain.
`define TEFS_FILT_LEN     4
`define TEFS_SYNC_LAT     3'h3

`endif

// File: design/tefs_pkg.sv
/*
 * Types of the event, fault and status block.
 * Assumes nothing of its surroundings.
 */
package tefs_pkg;

    typedef enum logic [1:0] {
        TEFS_CFG_NONE,
        TEFS_CFG_FILTER,
        TEFS_CFG_ASYNC,
        TEFS_CFG_RESERVED
    } tefs_cfg_e;

    typedef enum logic [3:0] {
        TEFS_FM_NONE,
        TEFS_FM_JUMP_OPPOSITE_AND_HOLD,
        TEFS_FM_RUN_OPPOSITE_AND_HOLD,
        TEFS_FM_RUN_OPPOSITE_WHILE_FAULTED,
        TEFS_FM_ALL_OFF_KEEP_PERIOD,
        TEFS_FM_ALL_OFF_RUN_DEADTIME,
        TEFS_FM_ALL_OFF_JUMP_AND_HOLD,
        TEFS_FM_ALL_OFF_AWAIT_SOFTWARE,
        TEFS_FM_EDGE_STOP_NEXT_CYCLE,
        TEFS_FM_EDGE_STOP_KEEP_PERIOD,
        TEFS_FM_LEVEL_STOP_KEEP_PERIOD
    } tefs_fmode_e;

    // Decoded fault response: stop one, stop all, jump, hold, keep period.
    typedef logic [4:0] tefs_resp_t;

endpackage

// File: design/tefs_event_fault_status.sv
/*
 * Event inputs, fault and capture qualification, interrupt flags and
 * synchronisation status of a control timer, as an APB slave.
 * Assumes event pins are asynchronous, waveform and cycle-end signals come
 * from timer logic on pclk, and the counter itself lives elsewhere.
 */
// What this block does
// - Filtered input changes only after four equal consecutive samples.
// - Filtered capture occurs four cycles after the unfiltered capture would.
// - Async option drives the fault output straight from the pin.
// - Config field 7:6: 0 plain, 1 filter, 2 asynchronous.
// - Polarity bit 4: 0 falling/low active, 1 rising/high active.
// - Action bit 2: 0 fault only, 1 fault and capture.
// - Bit 0 enables event as trigger; first register A, second B.
// - Enable bits 3 and 2 gate trigger B and trigger A requests.
// - Enable bit 0 gates the cycle-end interrupt request.
// - Trigger flags set on trigger or capture of their input.
// - Cycle-end flag bit 0 sets at every timer cycle end.
// - Writing one clears a flag; writing zero leaves it.
// - Activity bits 7 and 6 set on any level change of B and A.
// - Command-ready rises after sync; cleared by a command strobe in bits 4:0 or auto-load.
// - Enable-ready rises after sync; cleared by enable write, disable strobe, break.
// - Fault modes 0 to 3: none, or stop output on opposite cycle variants.
// - Fault modes 4 to 7 stop all outputs with their continuation.
// - Modes 8, 9, 10: edge jump, edge keep period, level keep period.
// - Command strobes act only while no command sync is pending.
// - Enable and disable strobe change only while no enable sync runs.
`timescale 1ns/10ps
`default_nettype none
`include "tefs_defines.svh"

module tefs_event_fault_status
    import tefs_pkg::*;
(
    input  wire logic       pclk,            // APB and timer clock, 20 MHz
    input  wire logic       presetn,         // Asynchronous reset, active low
    input  wire logic       psel,            // APB select
    input  wire logic       penable,         // APB access phase
    input  wire logic       pwrite,          // APB direction, high is write
    input  wire logic [9:0] paddr,           // APB byte address
    input  wire logic [31:0] pwdata,         // APB write data
    output logic      [31:0] prdata,         // APB read data
    output logic            pready,          // APB ready
    output logic            pslverr,         // APB error on unmapped address
    input  wire logic       event_a_in,      // Event input A, asynchronous
    input  wire logic       event_b_in,      // Event input B, asynchronous
    input  wire logic       waveform_output_a, // Waveform A from timer logic
    input  wire logic       waveform_output_b, // Waveform B from timer logic
    input  wire logic       cycle_end,       // End-of-cycle pulse from counter
    input  wire logic       debug_break,     // Debugger halt level
    output logic            async_fault_a,   // Unclocked fault path A
    output logic            async_fault_b,   // Unclocked fault path B
    output logic            fault_a,         // Qualified fault level A
    output logic            fault_b,         // Qualified fault level B
    output logic            capture_a,       // Capture pulse A
    output logic            capture_b,       // Capture pulse B
    output logic [3:0]      fault_response_mode, // Fault mode of input A
    output tefs_resp_t      fault_response,  // Decoded fault response of A
    output logic            trigger_input_a_irq, // Trigger A request
    output logic            trigger_input_b_irq, // Trigger B request
    output logic            cycle_end_irq,   // Cycle-end request
    output logic            load_eoc_cmd,    // Load at cycle end, pulse
    output logic            load_now_cmd,    // Immediate load, pulse
    output logic            restart_cmd,     // Counter restart, pulse
    output logic            soft_capture_a_cmd, // Software capture A, pulse
    output logic            soft_capture_b_cmd, // Software capture B, pulse
    output logic            timer_enable     // Synchronised enable level
);

    function automatic tefs_resp_t fm_decode(input logic [3:0] m);
        return {m inside {4'h4, 4'h9, 4'hA}, m inside {4'h1, 4'h2, 4'h6, 4'h7},
                m inside {4'h1, 4'h6, 4'h8}, m inside {[4'h4:4'h7]},
                m inside {[4'h1:4'h3], [4'h8:4'hA]}};
    endfunction

    // Event path: 2-FF sync, optional run-length filter, polarity, edge.
    logic [7:0] eva_q, evb_q, ien_q, flg_q, fma_q, ctl_q;
    logic       acta_q, actb_q;
    logic [1:0] sa_q, sb_q;
    logic [2:0] ha_q, hb_q;
    logic       fa_q, fb_q, pa_q, pb_q;
    logic       wa_q, wb_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sa_q <= 2'h0;
            sb_q <= 2'h0;
            ha_q <= 3'h0;
            hb_q <= 3'h0;
        end else begin
            sa_q <= {sa_q[0], event_a_in};
            sb_q <= {sb_q[0], event_b_in};
            ha_q <= {ha_q[1:0], sa_q[1]};
            hb_q <= {hb_q[1:0], sb_q[1]};
        end
    end

    wire tefs_cfg_e cfg_a = tefs_cfg_e'(eva_q[`TEFS_EV_CFG_HI:`TEFS_EV_CFG_LO]);
    wire tefs_cfg_e cfg_b = tefs_cfg_e'(evb_q[`TEFS_EV_CFG_HI:`TEFS_EV_CFG_LO]);
    wire run_a = (ha_q == {3{sa_q[1]}});
    wire run_b = (hb_q == {3{sb_q[1]}});
    // Code 3 falls through to the plain path, as does code 0.
    wire sel_a = (cfg_a == TEFS_CFG_FILTER) ? fa_q : sa_q[1];
    wire sel_b = (cfg_b == TEFS_CFG_FILTER) ? fb_q : sb_q[1];
    wire act_lvl_a = (sel_a == eva_q[`TEFS_EV_POL]);
    wire act_lvl_b = (sel_b == evb_q[`TEFS_EV_POL]);
    wire edge_a = (sel_a != pa_q) && act_lvl_a;
    wire edge_b = (sel_b != pb_q) && act_lvl_b;
    wire trg_a = eva_q[`TEFS_EV_TRIG] && edge_a;
    wire trg_b = evb_q[`TEFS_EV_TRIG] && edge_b;
    wire cap_a = trg_a && eva_q[`TEFS_EV_ACT];
    wire cap_b = trg_b && evb_q[`TEFS_EV_ACT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fa_q <= 1'b0;
            fb_q <= 1'b0;
            pa_q <= 1'b0;
            pb_q <= 1'b0;
        end else begin
            // Unfiltered edges are seen on the synchroniser output at once,
            // so the filter adds exactly its run length of delay.
            if (run_a) fa_q <= sa_q[1];
            if (run_b) fb_q <= sb_q[1];
            pa_q <= sel_a;
            pb_q <= sel_b;
        end
    end

    // The async path is deliberately combinational from the pin: it must
    // act on the outputs even with the clock stopped, at the cost of noise.
    assign async_fault_a = (cfg_a == TEFS_CFG_ASYNC) && eva_q[`TEFS_EV_TRIG]
                           && (event_a_in == eva_q[`TEFS_EV_POL]);
    assign async_fault_b = (cfg_b == TEFS_CFG_ASYNC) && evb_q[`TEFS_EV_TRIG]
                           && (event_b_in == evb_q[`TEFS_EV_POL]);

    // APB: one wait state, so every answer comes from a flip-flop.
    wire        acc   = psel && penable;
    wire        fire  = acc && pready;
    wire [7:0]  idx   = paddr[9:2];
    wire        wr    = fire && pwrite;
    wire [7:0]  wd    = pwdata[7:0];
    wire        hit   = (idx == `TEFS_IDX_EVA) || (idx == `TEFS_IDX_EVB) ||
                        (idx == `TEFS_IDX_IEN) || (idx == `TEFS_IDX_FLG) ||
                        (idx == `TEFS_IDX_STA) || (idx == `TEFS_IDX_FMA) ||
                        (idx == `TEFS_IDX_CMD) || (idx == `TEFS_IDX_CTL) ||
                        (idx == `TEFS_IDX_CMPBH);
    wire        w_eva = wr && (idx == `TEFS_IDX_EVA);
    wire        w_evb = wr && (idx == `TEFS_IDX_EVB);
    wire        w_ien = wr && (idx == `TEFS_IDX_IEN);
    wire        w_flg = wr && (idx == `TEFS_IDX_FLG);
    wire        w_sta = wr && (idx == `TEFS_IDX_STA);
    wire        w_fma = wr && (idx == `TEFS_IDX_FMA);
    wire        w_cmd = wr && (idx == `TEFS_IDX_CMD);
    wire        w_ctl = wr && (idx == `TEFS_IDX_CTL);
    wire        w_cbh = wr && (idx == `TEFS_IDX_CMPBH);

    // Command and enable crossings into the timer domain.
    logic [2:0] ccnt_q, ecnt_q;
    logic [4:0] cpend_q;
    logic       en_val_q, dis_pend_q, brk_q;
    wire        cmd_idle = (ccnt_q == 3'h0);
    wire        en_idle  = (ecnt_q == 3'h0) && !dis_pend_q;
    wire        cmd_take = (w_cmd && (wd[4:0] != 5'h00) ||
                            (w_cbh && ctl_q[`TEFS_CTL_AUTO])) && cmd_idle;
    wire        en_take  = w_ctl && en_idle;
    wire        dis_take = w_cmd && wd[`TEFS_CMD_DISABLE_AT_CYCLE_END_STROBE] && en_idle;
    wire        brk_hit  = debug_break && !brk_q && !ctl_q[`TEFS_CTL_RUN_DURING_BREAK];
    wire [2:0]  ccnt_m1  = ccnt_q - 3'h1;
    wire [2:0]  ecnt_m1  = ecnt_q - 3'h1;
    wire        cdone    = (ccnt_q == 3'h1);
    wire        edone    = (ecnt_q == 3'h1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ccnt_q  <= `TEFS_SYNC_LAT;
            cpend_q <= 5'h00;
        end else if (cmd_take) begin
            ccnt_q  <= `TEFS_SYNC_LAT;
            cpend_q <= w_cmd ? wd[4:0] : 5'h01;
        end else if (ccnt_q != 3'h0) begin
            ccnt_q  <= ccnt_m1;
            if (cdone) cpend_q <= 5'h00;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ecnt_q     <= `TEFS_SYNC_LAT;
            en_val_q   <= 1'b0;
            dis_pend_q <= 1'b0;
            brk_q      <= 1'b0;
        end else begin
            brk_q <= debug_break;
            if (brk_hit) begin
                ecnt_q   <= `TEFS_SYNC_LAT;
                en_val_q <= 1'b0;
            end else if (en_take) begin
                ecnt_q   <= `TEFS_SYNC_LAT;
                en_val_q <= wd[`TEFS_CTL_EN];
            end else if (ecnt_q != 3'h0) begin
                ecnt_q <= ecnt_m1;
            end
            // Enable-ready stays low until the cycle end really disables.
            if (dis_take) dis_pend_q <= 1'b1;
            else if (cycle_end) dis_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_enable       <= 1'b0;
            load_eoc_cmd       <= 1'b0;
            load_now_cmd       <= 1'b0;
            restart_cmd        <= 1'b0;
            soft_capture_a_cmd <= 1'b0;
            soft_capture_b_cmd <= 1'b0;
        end else begin
            if (dis_pend_q && cycle_end) timer_enable <= 1'b0;
            else if (edone) timer_enable <= en_val_q;
            load_eoc_cmd       <= cdone && cpend_q[`TEFS_CMD_LDEOC];
            load_now_cmd       <= cdone && cpend_q[`TEFS_CMD_LDNOW];
            restart_cmd        <= cdone && cpend_q[`TEFS_CMD_RST];
            soft_capture_a_cmd <= cdone && cpend_q[`TEFS_CMD_CAPA];
            soft_capture_b_cmd <= cdone && cpend_q[`TEFS_CMD_CAPB];
        end
    end

    // Configuration registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eva_q <= `TEFS_RST_VAL;
            evb_q <= `TEFS_RST_VAL;
            ien_q <= `TEFS_RST_VAL;
            fma_q <= `TEFS_RST_VAL;
            ctl_q <= `TEFS_RST_VAL;
        end else begin
            if (w_eva) eva_q <= wd & `TEFS_EV_MASK;
            if (w_evb) evb_q <= wd & `TEFS_EV_MASK;
            if (w_ien) ien_q <= wd & `TEFS_IRQ_MASK;
            if (w_fma) fma_q <= wd & `TEFS_FMA_MASK;
            if (w_ctl) begin
                ctl_q[7:1] <= {5'h00, wd[`TEFS_CTL_RUN_DURING_BREAK], wd[`TEFS_CTL_AUTO]};
                if (en_take) ctl_q[`TEFS_CTL_EN] <= wd[`TEFS_CTL_EN];
            end
        end
    end

    // Flags: a hardware set in the same cycle as a clear wins.
    wire [7:0] flg_set = {4'h0, trg_b || cap_b, trg_a || cap_a, 1'b0,
                          cycle_end};
    wire [7:0] flg_clr = w_flg ? (wd & `TEFS_IRQ_MASK) : 8'h00;
    wire       tog_a   = waveform_output_a != wa_q;
    wire       tog_b   = waveform_output_b != wb_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flg_q  <= `TEFS_RST_VAL;
            acta_q <= 1'b0;
            actb_q <= 1'b0;
            wa_q   <= 1'b0;
            wb_q   <= 1'b0;
        end else begin
            flg_q  <= (flg_q & ~flg_clr) | flg_set;
            wa_q   <= waveform_output_a;
            wb_q   <= waveform_output_b;
            acta_q <= tog_a || (acta_q && !(w_sta && wd[`TEFS_ST_ACTA]));
            actb_q <= tog_b || (actb_q && !(w_sta && wd[`TEFS_ST_ACTB]));
        end
    end

    wire [7:0] sta = {actb_q, acta_q, 4'h0, cmd_idle, en_idle};
    wire [7:0] rmux = (idx == `TEFS_IDX_EVA) ? eva_q :
                      (idx == `TEFS_IDX_EVB) ? evb_q :
                      (idx == `TEFS_IDX_IEN) ? ien_q :
                      (idx == `TEFS_IDX_FLG) ? flg_q :
                      (idx == `TEFS_IDX_STA) ? sta   :
                      (idx == `TEFS_IDX_FMA) ? fma_q :
                      (idx == `TEFS_IDX_CTL) ? ctl_q : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc && !pready;
            prdata  <= (acc && !pready && !pwrite) ? {24'h000000, rmux} : 32'h00000000;
            pslverr <= acc && !pready && !hit;
        end
    end

    // Registered event outputs and interrupt requests.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_a             <= 1'b0;
            fault_b             <= 1'b0;
            capture_a           <= 1'b0;
            capture_b           <= 1'b0;
            fault_response_mode <= 4'h0;
            fault_response      <= '0;
            trigger_input_a_irq <= 1'b0;
            trigger_input_b_irq <= 1'b0;
            cycle_end_irq       <= 1'b0;
        end else begin
            fault_a   <= eva_q[`TEFS_EV_TRIG] && act_lvl_a;
            fault_b   <= evb_q[`TEFS_EV_TRIG] && act_lvl_b;
            capture_a <= cap_a;
            capture_b <= cap_b;
            fault_response_mode <= fma_q[3:0];
            fault_response      <= fm_decode(fma_q[3:0]);
            trigger_input_a_irq <= flg_q[`TEFS_IRQ_TRA] && ien_q[`TEFS_IRQ_TRA];
            trigger_input_b_irq <= flg_q[`TEFS_IRQ_TRB] && ien_q[`TEFS_IRQ_TRB];
            cycle_end_irq <= flg_q[`TEFS_IRQ_OVF] && ien_q[`TEFS_IRQ_OVF];
        end
    end

endmodule
`default_nettype wire

// File: testbench/tefs_far_side.sv
/*
 * Far-side model of the event, fault and status block: event routing and
 * timer logic that drive the event pins, waveforms, cycle end and break.
 * Assumes the bench sets the wanted levels just after a rising pclk edge.
 */
`timescale 1ns/10ps
`default_nettype none

module tefs_far_side (
    input  wire logic pclk,              // Clock
    input  wire logic presetn,           // Reset, active low
    input  wire logic ea,                // Wanted level of event A
    input  wire logic eb,                // Wanted level of event B
    input  wire logic wa,                // Wanted waveform A
    input  wire logic wb,                // Wanted waveform B
    input  wire logic eoc,               // Each toggle asks for one cycle end
    input  wire logic brk,               // Wanted break level
    output logic      event_a_in,        // Event pin A
    output logic      event_b_in,        // Event pin B
    output logic      waveform_output_a, // Waveform A
    output logic      waveform_output_b, // Waveform B
    output logic      cycle_end,         // One-cycle cycle-end pulse
    output logic      debug_break        // Break level
);
    logic eoc_q;

    // Toggling keeps each pulse one cycle long.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {event_a_in, event_b_in, waveform_output_a, waveform_output_b} <= 4'h0;
            {cycle_end, debug_break, eoc_q} <= 3'h0;
        end else begin
            {event_a_in, event_b_in, waveform_output_a, waveform_output_b} <= {ea, eb, wa, wb};
            eoc_q <= eoc;
            cycle_end <= eoc ^ eoc_q;
            debug_break <= brk;
        end
    end
endmodule

`default_nettype wire

// File: testbench/tefs_monitor.sv
/*
 * Checker of the event, fault and status block, bound to its top module.
 * Assumes one clock domain and that only the design drives the outputs.
 */
`timescale 1ns/10ps
`default_nettype none
`include "tefs_defines.svh"

module tefs_monitor
    import tefs_pkg::*;
(
    input wire logic       pclk,                // Clock
    input wire logic       presetn,             // Reset
    input wire logic       psel,                // Select
    input wire logic       penable,             // Access
    input wire logic       pwrite,              // Write
    input wire logic [9:0] paddr,               // Address
    input wire logic [31:0] prdata,             // Read data
    input wire logic       pready,              // Ready
    input wire logic       pslverr,             // Error
    input wire logic       capture_a,           // Capture A
    input wire logic       fault_a,             // Fault A
    input wire logic       cycle_end,           // Cycle end
    input wire logic       cycle_end_irq,       // Cycle-end request
    input wire logic       restart_cmd,         // Restart
    input wire logic       load_now_cmd,        // Load now
    input wire logic       soft_capture_a_cmd,  // Capture A strobe
    input wire logic       soft_capture_b_cmd,  // Capture B strobe
    input wire logic [3:0] fault_response_mode, // Mode
    input wire tefs_resp_t fault_response       // Response
);
    logic [7:0] since_wr_q;
    wire        apb_wr = psel && penable && pready && pwrite;
    wire        cmd_wr = apb_wr && (paddr[9:2] == `TEFS_IDX_CMD);
    wire        cmd_any = restart_cmd || load_now_cmd || soft_capture_a_cmd || soft_capture_b_cmd;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) since_wr_q <= 8'hFF;
        else if (cmd_wr) since_wr_q <= 8'h00;
        else if (since_wr_q != 8'hFF) since_wr_q <= since_wr_q + 8'h01;
    end

    a_ready_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_cap_fault: assert property (capture_a |-> ##[0:2] fault_a)
        else $error("capture without fault");
    a_cap_pulse: assert property (capture_a |=> !capture_a)
        else $error("capture longer than one cycle");
    a_cmd_gap: assert property (cmd_any |=> !cmd_any [*2])
        else $error("command pulses too close");
    a_cmd_cause: assert property (cmd_any |-> since_wr_q inside {[8'd1:8'd6]})
        else $error("command pulse without write");
    a_resp_none: assert property (fault_response_mode == 4'h0 |-> fault_response == 5'h00)
        else $error("response for mode none");
    a_resp_all: assert property (fault_response_mode inside {[4'h4:4'h7]}
        |-> fault_response[1] && !fault_response[0])
        else $error("all-off mode not decoded");
    a_ovf_irq: assert property ($rose(cycle_end_irq) |-> $past(cycle_end, 2) ||
        $past(cycle_end, 3) || $past(apb_wr, 2) || $past(apb_wr, 3))
        else $error("cycle-end request without cause");
endmodule

bind tefs_event_fault_status tefs_monitor mon_u (.*);

`default_nettype wire

// File: testbench/test_timer_event_fault_status.sv
/*
 * Self-checking bench of the event, fault and status block: APB tasks and
 * directed sequences. Assumes the far-side model and the bound checker.
 */
`timescale 1ns/10ps
`default_nettype none
`include "tefs_defines.svh"
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_fail++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
`define WT(n) begin repeat (n) @(posedge pclk); #1; end
`define WAITC(s) begin cyc = 0; while (s !== 1'b1 && cyc < 40) begin \
    @(posedge pclk); #1; cyc++; end \
    if (cyc >= 40) begin n_fail++; summarize(); end end

module test_timer_event_fault_status;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [9:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdv;
    logic        pready, pslverr, erv, event_a_in, event_b_in;
    logic        waveform_output_a, waveform_output_b, cycle_end, debug_break;
    logic        async_fault_a, async_fault_b, fault_a, fault_b, capture_a, capture_b;
    logic        trigger_input_a_irq, trigger_input_b_irq, cycle_end_irq, timer_enable;
    logic        load_eoc_cmd, load_now_cmd, restart_cmd, soft_capture_a_cmd;
    logic        soft_capture_b_cmd;
    logic [3:0]  fault_response_mode;
    logic [4:0]  fault_response;
    logic        ea = 0, eb = 0, wa = 0, wb = 0, eoc = 0, brk = 0;
    int          n_fail = 0, checked = 0, cyc, l0, k;
    int          n_ca = 0, n_cb = 0, n_cmd = 0, n_le = 0;

    tefs_event_fault_status dut_u (.*);
    tefs_far_side far_u (.*);

    always #25 pclk = ~pclk;

    // Pulses are counted mid-cycle, off the launching edge.
    always @(negedge pclk) begin
        n_ca += int'(capture_a === 1'b1);
        n_cb += int'(capture_b === 1'b1);
        n_cmd += int'({restart_cmd, load_now_cmd, soft_capture_a_cmd} === 3'h7);
        n_le += int'(load_eoc_cmd === 1'b1);
    end

    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int   n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin n_fail++; summarize(); end
        #1;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rd(input logic [7:0] idx);
        apb(1'b0, idx, 8'h00);
    endtask

    function automatic logic [4:0] resp(input int m);
        resp = {m inside {4, 9, 10}, m inside {1, 2, 6, 7}, m inside {1, 6, 8},
                m inside {[4:7]}, m inside {1, 2, 3, 8, 9, 10}};
    endfunction

    task summarize;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge pclk);
        n_fail++;
        summarize();
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        `WT(6)
        rd(`TEFS_IDX_STA);
        `CHK("status", 32'h3, rdv)
        rd(8'h3F);
        `CHK("unmapped", 1'b1, erv)
        wr(`TEFS_IDX_EVA, 8'h15);
        ea <= 1'b1;
        `WAITC(capture_a)
        l0 = cyc;
        ea <= 1'b0;
        `WT(8)
        wr(`TEFS_IDX_EVA, 8'h55);
        ea <= 1'b1;
        `WAITC(capture_a)
        `CHK("filter delay", l0 + 4, cyc)
        ea <= 1'b0;
        `WT(8)
        k = n_ca;
        ea <= 1'b1;
        `WT(2)
        ea <= 1'b0;
        `WT(10)
        `CHK("glitch", k, n_ca)
        wr(`TEFS_IDX_EVA, 8'h05);
        ea <= 1'b1;
        `WT(8)
        `CHK("rise pol0", k, n_ca)
        ea <= 1'b0;
        `WT(8)
        `CHK("fall pol0", k + 1, n_ca)
        wr(`TEFS_IDX_EVA, 8'h11);
        ea <= 1'b1;
        `WT(8)
        `CHK("fault only", 1'b1, fault_a)
        `CHK("no capture", k + 1, n_ca)
        wr(`TEFS_IDX_EVA, 8'h10);
        `WT(2)
        `CHK("trigger off", 1'b0, fault_a)
        wr(`TEFS_IDX_EVA, 8'h91);
        ea <= 1'b0;
        `WT(1)
        `CHK("async low", 1'b0, async_fault_a)
        ea <= 1'b1;
        `WT(1)
        `CHK("async high", 1'b1, async_fault_a)
        wr(`TEFS_IDX_EVA, 8'hD1);
        `CHK("reserved cfg", 1'b0, async_fault_a)
        ea <= 1'b0;
        wr(`TEFS_IDX_EVB, 8'h15);
        eb <= 1'b1;
        `WT(8)
        `CHK("capture b", 1, n_cb)
        eb <= 1'b0;
        `WT(6)
        rd(`TEFS_IDX_FLG);
        `CHK("flags", 32'hC, rdv)
        wr(`TEFS_IDX_IEN, 8'h0C);
        `WT(2)
        `CHK("irq b", 1'b1, trigger_input_b_irq)
        wr(`TEFS_IDX_FLG, 8'h04);
        rd(`TEFS_IDX_FLG);
        `CHK("w1c", 32'h8, rdv)
        `CHK("irq a off", 1'b0, trigger_input_a_irq)
        eoc <= ~eoc;
        `WT(4)
        rd(`TEFS_IDX_FLG);
        `CHK("cycle end", 32'h9, rdv)
        `CHK("ovf masked", 1'b0, cycle_end_irq)
        wr(`TEFS_IDX_IEN, 8'h0D);
        `WT(2)
        `CHK("ovf irq", 1'b1, cycle_end_irq)
        wr(`TEFS_IDX_FLG, 8'h09);
        `WT(2)
        `CHK("ovf clear", 1'b0, cycle_end_irq)
        wa <= 1'b1;
        `WT(4)
        wb <= 1'b1;
        wr(`TEFS_IDX_STA, 8'h40);
        rd(`TEFS_IDX_STA);
        `CHK("act clr", 2'b10, rdv[7:6])
        wa <= 1'b0;
        `WT(4)
        rd(`TEFS_IDX_STA);
        `CHK("act again", 2'b11, rdv[7:6])
        for (int m = 0; m < 11; m++) begin
            wr(`TEFS_IDX_FMA, 8'(m));
            `WT(2)
            `CHK("response", resp(m), fault_response)
        end
        wr(`TEFS_IDX_CMD, 8'h0E);
        `WT(8)
        `CHK("strobes", 1, n_cmd)
        wr(`TEFS_IDX_CTL, 8'h02);
        wr(`TEFS_IDX_CMPBH, 8'h00);
        `WT(8)
        `CHK("auto load", 1, n_le)
        wr(`TEFS_IDX_CTL, 8'h01);
        `WAITC(timer_enable)
        `CHK("enable", 1'b1, timer_enable)
        `WT(6)
        wr(`TEFS_IDX_CMD, 8'h80);
        rd(`TEFS_IDX_STA);
        `CHK("en busy", 1'b0, rdv[0])
        wr(`TEFS_IDX_CTL, 8'h00);
        `CHK("refused", 1'b1, timer_enable)
        eoc <= ~eoc;
        `WT(6)
        `CHK("disabled", 1'b0, timer_enable)
        wr(`TEFS_IDX_CTL, 8'h01);
        `WT(10)
        brk <= 1'b1;
        `WT(6)
        `CHK("break", 1'b0, timer_enable)
        summarize();
    end
endmodule

`default_nettype wire
